// file: shared/ast_params.svh
`ifndef AST_PARAMS_SVH
`define AST_PARAMS_SVH

// ****************************************
// Register offsets, byte addresses
// ****************************************
`define AST_OFF_SWAP      15'h0048
`define AST_OFF_STC       15'h010c
`define AST_OFF_CFG_STAT  15'h0110
`define AST_OFF_REQ_IN    15'h0114
`define AST_OFF_ADP_ERR   15'h013c
`define AST_OFF_DOORBELL  15'h01c0
`define AST_OFF_IRQ_SET   15'h01e0
`define AST_OFF_IRQ_CLR   15'h01e4
`define AST_OFF_MASK_SET  15'h01e8
`define AST_OFF_MASK_CLR  15'h01ec
`define AST_OFF_PIO_CLR   15'h01f0
`define AST_EXT_COUNT     9

// ****************************************
// Reset and documented register values
// ****************************************
`define AST_SWAP_RST      32'h0000_0000
`define AST_STC_PCI_VAL   32'hf700_0000
`define AST_CAUSE_SOFT    4'h9
`define AST_CAUSE_TEST    4'hc
`define AST_CAUSE_PCI     4'hf

// ****************************************
// Field positions
// ****************************************
`define AST_SWP_ST_DONE   25
`define AST_SWP_POT_DONE  24
`define AST_STC_CAUSE_LO  28
`define AST_STC_DONE      26
`define AST_STC_CPU_RST   23
`define AST_STC_CLR_FMASK 22
`define AST_STC_PASS_LO   16
`define AST_STC_FAIL_LO   13
`define AST_STC_FMASK     9
`define AST_STC_SET_FMASK 6
`define AST_STC_SET_CPU   4
`define AST_STC_SOFT_RST  1
`define AST_STC_START     0

`endif

// file: shared/ast_pkg.sv
package ast_pkg;

    typedef enum logic [1:0] {
        AST_SP_CFG,
        AST_SP_MEM,
        AST_SP_IO
    } ast_space_e;

    typedef struct packed {
        logic [31:0] swap;
        logic [3:0]  cause;
        logic        done;
        logic        cpu_rst;
        logic        fmask;
        logic        flash_rst;
        logic [2:0]  pass;
        logic [2:0]  fail;
        logic        ack;
        logic        rd_valid;
        logic        hit;
        logic [31:0] rd_data;
        logic [8:0]  ext_sel;
        logic        ext_wr;
        logic        start;
        logic        soft_req;
    } ast_ctl_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } ast_swp_s;

endpackage

// file: shared/ast_dec_if.sv
`timescale 1ns/10ps
interface ast_dec_if;
    ast_pkg::ast_space_e space;
    logic [14:0]         addr;
    logic [6:0]          io_page;
    logic                sel_swap;
    logic                swap_wr_ok;
    logic                sel_stc;
    logic [8:0]          sel_ext;

    modport dec (
        input  space, addr, io_page,
        output sel_swap, swap_wr_ok, sel_stc, sel_ext
    );
    modport ctl (
        output space, addr, io_page,
        input  sel_swap, swap_wr_ok, sel_stc, sel_ext
    );
endinterface

// file: verilog/ast_decode.sv
`timescale 1ns/10ps
`include "ast_params.svh"
module ast_decode (
    // Decode request and selects
    ast_dec_if.dec bus
);
    localparam logic [14:0] EXT_OFF [`AST_EXT_COUNT] = '{
        `AST_OFF_CFG_STAT, `AST_OFF_REQ_IN, `AST_OFF_ADP_ERR,
        `AST_OFF_DOORBELL, `AST_OFF_IRQ_SET, `AST_OFF_IRQ_CLR,
        `AST_OFF_MASK_SET, `AST_OFF_MASK_CLR, `AST_OFF_PIO_CLR
    };

    logic [14:0] eff;
    logic        win;

    // ****************************************
    // Effective offset per space
    // ****************************************
    // I/O sees 256 bytes at a time, page picks the window
    always_comb begin
        case (bus.space)
            ast_pkg::AST_SP_IO:  eff = {bus.io_page, bus.addr[7:0]};
            ast_pkg::AST_SP_MEM: eff = bus.addr;
            default:             eff = {7'h00, bus.addr[7:0]};
        endcase
    end

    assign win = (bus.space == ast_pkg::AST_SP_MEM) ||
                 (bus.space == ast_pkg::AST_SP_IO);

    // No space selected must not alias the swap register
    assign bus.sel_swap   = (win || bus.swap_wr_ok) &&
                            (eff == `AST_OFF_SWAP);
    assign bus.swap_wr_ok = (bus.space == ast_pkg::AST_SP_CFG);
    assign bus.sel_stc    = win && (eff == `AST_OFF_STC);

    generate
        for (genvar i = 0; i < `AST_EXT_COUNT; i++) begin : g_ext
            assign bus.sel_ext[i] = win && (eff == EXT_OFF[i]);
        end
    endgenerate
endmodule

// file: verilog/ast_swap.sv
`timescale 1ns/10ps
module ast_swap (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_clock_en,
    // Swap enables, window0..window4 then window6
    input  wire logic [5:0]  i_swap_en,
    // Target data in
    input  wire logic        i_tgt_valid,
    input  wire logic [2:0]  i_tgt_bar,
    input  wire logic [31:0] i_tgt_data,
    // Target data out
    output logic             o_tgt_valid,
    output logic [31:0]      o_tgt_data
);
    ast_pkg::ast_swp_s q, d;
    logic [31:0]       rev;
    logic              en;

    generate
        for (genvar k = 0; k < 4; k++) begin : g_byte
            assign rev[8*k +: 8] = i_tgt_data[8*(3-k) +: 8];
        end
    endgenerate

    // Window 5 has no enable and always passes straight
    always_comb begin
        case (i_tgt_bar)
            3'h0:    en = i_swap_en[5];
            3'h1:    en = i_swap_en[4];
            3'h2:    en = i_swap_en[3];
            3'h3:    en = i_swap_en[2];
            3'h4:    en = i_swap_en[1];
            3'h6:    en = i_swap_en[0];
            default: en = 1'b0;
        endcase
    end

    always_comb begin
        d = q;
        d.valid = i_tgt_valid;
        if (i_tgt_valid) begin
            d.data = en ? rev : i_tgt_data;
        end
        if (!i_resetn) begin
            d = '0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_clock_en || !i_resetn) begin
            q <= d;
        end
    end

    assign o_tgt_valid = q.valid;
    assign o_tgt_data  = q.data;
endmodule

// file: verilog/ast_ctrl.sv
`timescale 1ns/10ps
`include "ast_params.svh"
// What this block does
// - Swap bits 31..27 windows 0..4, bit 26 window 6 reverse bytes
// - Swap register at config 48h, resets zero, read-only via mem and I/O
// - Swap bit 25 set by firmware after self-test ran
// - Swap bit 24 set by firmware when product data is readable
// - Decode communication registers at their memory offsets
// - Same registers reachable through 256-byte I/O windows
// - Self-test register reached at I/O 100h+0Ch and in memory space
// - Reads F7000000 after reset, C7000000 after test, 97000000 soft
// - Bits 31..28 hold last reset cause: 1001, 1100 or 1111
// - Bit 27 always reads zero
// - Bit 26 set when test or soft reset ends; write 1 clears
// - Bit 23 shows local cpu reset; write 1 releases it
// - Bits 18..16 set when array tests pass
// - Bits 15..13 set when array tests fail
// - Flash resets with local cpu unless flash mask is set
// - Write 1 to bit 4 asserts local cpu reset
module ast_ctrl (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic        i_clock_en,
    // Register access from target
    input  wire logic        i_acc_valid,
    input  wire logic        i_acc_write,
    input  wire logic [1:0]  i_acc_space,
    input  wire logic [14:0] i_acc_addr,
    input  wire logic [6:0]  i_io_page,
    input  wire logic [3:0]  i_acc_be,
    input  wire logic [31:0] i_acc_wdata,
    // Register access answer
    output logic             o_ack,
    output logic             o_acc_hit,
    output logic             o_rd_valid,
    output logic [31:0]      o_rd_data,
    output logic [8:0]       o_ext_select,
    output logic             o_ext_write,
    // Local firmware and test engine events
    input  wire logic        i_fw_self_test_done,
    input  wire logic        i_fw_power_on_done,
    input  wire logic        i_test_begin,
    input  wire logic        i_soft_reset_begin,
    input  wire logic        i_test_finish,
    input  wire logic [2:0]  i_array_pass,
    input  wire logic [2:0]  i_array_fail,
    // Reset and test controls
    output logic             o_local_cpu_reset,
    output logic             o_flash_reset,
    output logic             o_start_self_test,
    output logic             o_soft_reset_req,
    // Target data path
    input  wire logic        i_tgt_valid,
    input  wire logic [2:0]  i_tgt_bar,
    input  wire logic [31:0] i_tgt_data,
    output logic             o_tgt_valid,
    output logic [31:0]      o_tgt_data
);
    ast_pkg::ast_ctl_s q, d;
    ast_dec_if         dif ();
    logic [31:0]       stc_word;
    logic [31:0]       wmask;
    logic [31:0]       stc_w;
    logic              rd_req;
    logic              wr_req;
    logic              any_hit;

    // ****************************************
    // Address decode
    // ****************************************
    assign dif.space   = ast_pkg::ast_space_e'(i_acc_space);
    assign dif.addr    = i_acc_addr;
    assign dif.io_page = i_io_page;

    ast_decode ast_decode_inst (
        .bus (dif.dec)
    );

    // ****************************************
    // Byte swap path
    // ****************************************
    ast_swap ast_swap_inst (
        .i_clock     (i_clock),
        .i_resetn    (i_resetn),
        .i_clock_en  (i_clock_en),
        .i_swap_en   (q.swap[31:26]),
        .i_tgt_valid (i_tgt_valid),
        .i_tgt_bar   (i_tgt_bar),
        .i_tgt_data  (i_tgt_data),
        .o_tgt_valid (o_tgt_valid),
        .o_tgt_data  (o_tgt_data)
    );

    // ****************************************
    // Write strobes
    // ****************************************
    generate
        for (genvar b = 0; b < 4; b++) begin : g_be
            assign wmask[8*b +: 8] = {8{i_acc_be[b]}};
        end
    endgenerate

    assign rd_req  = i_acc_valid && !i_acc_write;
    assign wr_req  = i_acc_valid && i_acc_write;
    assign any_hit = dif.sel_swap || dif.sel_stc || (|dif.sel_ext);
    // Only ones act, so zeros leave state alone
    assign stc_w   = (wr_req && dif.sel_stc) ?
                     (i_acc_wdata & wmask) : 32'h0000_0000;

    // ****************************************
    // Self-test register read view
    // ****************************************
    // Bits 25..24 read one, the rest unlisted read zero
    always_comb begin
        stc_word = 32'h0000_0000;
        stc_word[`AST_STC_CAUSE_LO +: 4] = q.cause;
        stc_word[`AST_STC_DONE]          = q.done;
        stc_word[25:24]                  = 2'b11;
        stc_word[`AST_STC_CPU_RST]       = q.cpu_rst;
        stc_word[`AST_STC_PASS_LO +: 3]  = q.pass;
        stc_word[`AST_STC_FAIL_LO +: 3]  = q.fail;
        stc_word[`AST_STC_FMASK]         = q.fmask;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d          = q;
        d.ack      = i_acc_valid;
        d.hit      = i_acc_valid && any_hit;
        d.rd_valid = rd_req;
        d.ext_sel  = i_acc_valid ? dif.sel_ext : 9'h000;
        d.ext_wr   = wr_req && (|dif.sel_ext);
        d.start    = stc_w[`AST_STC_START];
        d.soft_req = stc_w[`AST_STC_SOFT_RST];

        // Read answer
        if (rd_req) begin
            if (dif.sel_swap) begin
                d.rd_data = q.swap;
            end else if (dif.sel_stc) begin
                d.rd_data = stc_word;
            end else begin
                d.rd_data = 32'h0000_0000;
            end
        end

        // Swap control, writable from config only
        if (wr_req && dif.sel_swap && dif.swap_wr_ok) begin
            d.swap = (q.swap & ~wmask) | (i_acc_wdata & wmask);
        end
        // Firmware flags win over a host write in the same cycle
        if (i_fw_self_test_done) begin
            d.swap[`AST_SWP_ST_DONE] = 1'b1;
        end
        if (i_fw_power_on_done) begin
            d.swap[`AST_SWP_POT_DONE] = 1'b1;
        end

        // Reset cause and completion
        if (i_test_begin) begin
            d.cause = `AST_CAUSE_TEST;
            d.done  = 1'b0;
            d.pass  = 3'b000;
            d.fail  = 3'b000;
        end else if (i_soft_reset_begin) begin
            d.cause = `AST_CAUSE_SOFT;
            d.done  = 1'b0;
        end else if (stc_w[`AST_STC_DONE]) begin
            d.done = 1'b0;
        end
        // Finish beats a host clear arriving together
        if (i_test_finish) begin
            d.done = 1'b1;
        end

        // Array test results stick until the next test
        d.pass = d.pass | i_array_pass;
        d.fail = d.fail | i_array_fail;

        // Bits 25..24 take no action when written
        // Local cpu reset, assert wins over release
        if (stc_w[`AST_STC_SET_CPU]) begin
            d.cpu_rst = 1'b1;
        end else if (stc_w[`AST_STC_CPU_RST]) begin
            d.cpu_rst = 1'b0;
        end

        // Flash mask, set wins over clear
        if (stc_w[`AST_STC_SET_FMASK]) begin
            d.fmask = 1'b1;
        end else if (stc_w[`AST_STC_CLR_FMASK]) begin
            d.fmask = 1'b0;
        end

        // Flash held only while unmasked during a cpu reset
        d.flash_rst = d.cpu_rst && !d.fmask;

        if (!i_resetn) begin
            d       = '0;
            d.swap  = `AST_SWAP_RST;
            d.cause = `AST_CAUSE_PCI;
            d.done  = 1'b1;
        end
    end

    // ****************************************
    // State register
    // ****************************************
    // Reset acts even while the clock enable is low
    always_ff @(posedge i_clock) begin
        if (i_clock_en || !i_resetn) begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_ack             = q.ack;
    assign o_acc_hit         = q.hit;
    assign o_rd_valid        = q.rd_valid;
    assign o_rd_data         = q.rd_data;
    assign o_ext_select      = q.ext_sel;
    assign o_ext_write       = q.ext_wr;
    assign o_local_cpu_reset = q.cpu_rst;
    assign o_flash_reset     = q.flash_rst;
    assign o_start_self_test = q.start;
    assign o_soft_reset_req  = q.soft_req;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);

    sequence s_cfg_swap_wr;
        i_clock_en && wr_req && dif.sel_swap && dif.swap_wr_ok &&
        (i_acc_be == 4'hf) && !i_fw_self_test_done &&
        !i_fw_power_on_done;
    endsequence

    property p_swap_cfg_write;
        s_cfg_swap_wr |=> (q.swap == $past(i_acc_wdata));
    endproperty
    a_swap_cfg_write: assert property (p_swap_cfg_write)
        else $error("swap register missed a config write");

    property p_swap_read_only;
        i_clock_en && wr_req && dif.sel_swap && !dif.swap_wr_ok
        |=> (q.swap[31:26] == $past(q.swap[31:26]));
    endproperty
    a_swap_read_only: assert property (p_swap_read_only)
        else $error("swap register changed by a window write");

    property p_st_done_flag;
        i_clock_en && i_fw_self_test_done
        |=> q.swap[`AST_SWP_ST_DONE];
    endproperty
    a_st_done_flag: assert property (p_st_done_flag)
        else $error("self-test flag not set by firmware");

    property p_pot_done_flag;
        i_clock_en && i_fw_power_on_done |=> q.swap[`AST_SWP_POT_DONE];
    endproperty
    a_pot_done_flag: assert property (p_pot_done_flag)
        else $error("power-on flag not set by firmware");

    property p_reset_value;
        $rose(i_resetn) |-> (stc_word == `AST_STC_PCI_VAL);
    endproperty
    a_reset_value: assert property (p_reset_value)
        else $error("self-test register wrong after reset");

    sequence s_test_start;
        i_clock_en && i_test_begin && !i_test_finish;
    endsequence

    property p_test_cause;
        s_test_start |=> (q.cause == `AST_CAUSE_TEST) && !q.done;
    endproperty
    a_test_cause: assert property (p_test_cause)
        else $error("reset cause not set for self-test");

    property p_done_wins;
        i_clock_en && i_test_finish |=> stc_word[`AST_STC_DONE];
    endproperty
    a_done_wins: assert property (p_done_wins)
        else $error("completion flag lost");

    property p_reserved_zero;
        i_clock_en && rd_req && dif.sel_stc
        |=> (o_rd_data[27] == 1'b0) && (o_rd_data[22:19] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved self-test bits not zero");

    sequence s_cpu_set;
        i_clock_en && stc_w[`AST_STC_SET_CPU];
    endsequence

    property p_cpu_assert;
        s_cpu_set |=> o_local_cpu_reset && stc_word[`AST_STC_CPU_RST];
    endproperty
    a_cpu_assert: assert property (p_cpu_assert)
        else $error("local cpu reset not asserted");

    property p_cpu_release;
        i_clock_en && stc_w[`AST_STC_CPU_RST] &&
        !stc_w[`AST_STC_SET_CPU] |=> !o_local_cpu_reset;
    endproperty
    a_cpu_release: assert property (p_cpu_release)
        else $error("local cpu reset not released");

    property p_flash_follow;
        o_flash_reset == (o_local_cpu_reset && !q.fmask);
    endproperty
    a_flash_follow: assert property (p_flash_follow)
        else $error("flash reset does not follow cpu reset");

    property p_stc_read;
        i_clock_en && rd_req && dif.sel_stc
        |=> o_rd_valid && (o_rd_data == $past(stc_word));
    endproperty
    a_stc_read: assert property (p_stc_read)
        else $error("self-test read data wrong");

    property p_zero_write;
        i_clock_en && wr_req && dif.sel_stc && (i_acc_wdata == 32'h0) &&
        !i_test_begin && !i_soft_reset_begin && !i_test_finish &&
        (i_array_pass == 3'b000) && (i_array_fail == 3'b000)
        |=> (stc_word == $past(stc_word));
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("zero write changed self-test state");

    property p_pass_sticky;
        i_clock_en && i_array_pass[2] && !i_test_begin ##1 !i_test_begin
        |-> stc_word[18] [*2];
    endproperty
    a_pass_sticky: assert property (p_pass_sticky)
        else $error("array pass flag not held");
endmodule

// file: test/ast_host_model.sv
`timescale 1ns/10ps
module ast_host_model (
    // Clock
    input  wire logic        i_clock,
    // Answer from block
    input  wire logic        i_ack,
    input  wire logic        i_hit,
    input  wire logic [31:0] i_rd_data,
    // Access request to block
    output logic             o_valid,
    output logic             o_write,
    output logic [1:0]       o_space,
    output logic [14:0]      o_addr,
    output logic [6:0]       o_page,
    output logic [3:0]       o_be,
    output logic [31:0]      o_wdata
);
    logic [31:0] rd_q;
    logic        hit_q;
    int          lost;

    initial begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_space = 2'h3;
        o_addr  = 15'h0000;
        o_page  = 7'h00;
        o_be    = 4'hf;
        o_wdata = 32'h0000_0000;
        lost    = 0;
    end

    // Single word access; request stands for its taking edge only
    task automatic acc(input logic wr, input logic [1:0] sp,
                       input logic [14:0] a, input logic [6:0] pg,
                       input logic [31:0] d);
        logic [31:0] wd;
        int          n;
        wd = d;
        n  = 0;
        if (a[7:0] == 8'h48) wd[0] = 1'b0;
        if (a[7:0] == 8'h0c) wd[25:24] = 2'h0;
        @(posedge i_clock);
        o_valid <= 1'b1;
        o_write <= wr;
        o_space <= sp;
        o_addr  <= a;
        o_page  <= pg;
        o_wdata <= wd;
        @(posedge i_clock);
        o_valid <= 1'b0;
        o_wdata <= ~wd;
        #1;
        while (i_ack !== 1'b1 && n < 4) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (i_ack !== 1'b1) lost++;
        rd_q  = i_rd_data;
        hit_q = i_hit;
    endtask
endmodule

// file: test/tb_ast_ctrl.sv
`timescale 1ns/10ps
module tb_ast_ctrl;
    logic        i_clock, i_resetn, i_clock_en;
    logic        i_acc_valid, i_acc_write;
    logic [1:0]  i_acc_space;
    logic [14:0] i_acc_addr;
    logic [6:0]  i_io_page;
    logic [3:0]  i_acc_be;
    logic [31:0] i_acc_wdata, o_rd_data, i_tgt_data, o_tgt_data;
    logic        o_ack, o_acc_hit, o_rd_valid, o_ext_write;
    logic [8:0]  o_ext_select;
    logic        i_fw_self_test_done, i_fw_power_on_done, i_test_begin;
    logic        i_soft_reset_begin, i_test_finish;
    logic [2:0]  i_array_pass, i_array_fail, i_tgt_bar;
    logic        o_local_cpu_reset, o_flash_reset, o_start_self_test;
    logic        o_soft_reset_req, i_tgt_valid, o_tgt_valid;
    int          bad_count, n_compared;

    ast_ctrl ast_ctrl_inst (.*);

    ast_host_model ast_host_model_inst (
        .i_clock   (i_clock),
        .i_ack     (o_ack),
        .i_hit     (o_acc_hit),
        .i_rd_data (o_rd_data),
        .o_valid   (i_acc_valid),
        .o_write   (i_acc_write),
        .o_space   (i_acc_space),
        .o_addr    (i_acc_addr),
        .o_page    (i_io_page),
        .o_be      (i_acc_be),
        .o_wdata   (i_acc_wdata)
    );

    always #2.5 i_clock = ~i_clock;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [1:0] sp, input logic [14:0] a,
                      input logic [6:0] pg, input logic [31:0] d);
        ast_host_model_inst.acc(1'b1, sp, a, pg, d);
    endtask

    task automatic rd(input logic [1:0] sp, input logic [14:0] a,
                      input logic [6:0] pg, input logic [31:0] exp);
        ast_host_model_inst.acc(1'b0, sp, a, pg, 32'h0000_0000);
        chk({31'h0, o_rd_valid}, 32'h1);
        chk(ast_host_model_inst.rd_q, exp);
    endtask

    // Events in order: fw test, fw power-on, begin, soft, finish
    task automatic ev(input logic [4:0] e, input logic [2:0] p,
                      input logic [2:0] f);
        @(posedge i_clock);
        {i_fw_self_test_done, i_fw_power_on_done, i_test_begin,
         i_soft_reset_begin, i_test_finish} <= e;
        i_array_pass <= p;
        i_array_fail <= f;
        @(posedge i_clock);
        {i_fw_self_test_done, i_fw_power_on_done, i_test_begin,
         i_soft_reset_begin, i_test_finish} <= 5'h00;
        i_array_pass <= 3'h0;
        i_array_fail <= 3'h0;
    endtask

    task automatic tg(input logic [2:0] b, input logic [31:0] d,
                      input logic [31:0] exp);
        @(posedge i_clock);
        i_tgt_valid <= 1'b1;
        i_tgt_bar   <= b;
        i_tgt_data  <= d;
        @(posedge i_clock);
        i_tgt_valid <= 1'b0;
        i_tgt_data  <= ~d;
        #1;
        chk({31'h0, o_tgt_valid}, 32'h1);
        chk(o_tgt_data, exp);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rd(2'h0, 15'h0048, 7'h00, 32'h0000_0000);
        rd(2'h1, 15'h0048, 7'h00, 32'h0000_0000);
        rd(2'h1, 15'h010c, 7'h00, 32'hf700_0000);
        rd(2'h2, 15'h000c, 7'h01, 32'hf700_0000);
        rd(2'h1, 15'h0200, 7'h00, 32'h0000_0000);
        chk({31'h0, ast_host_model_inst.hit_q}, 32'h0);
        chk({31'h0, o_local_cpu_reset}, 32'h0);
    endtask

    task automatic t_swap;
        logic [31:0] en, d;
        for (int w = 0; w < 7; w++) begin
            if (w != 5) begin
                en = (w == 6) ? 32'h0400_0000 : (32'h8000_0000 >> w);
                wr(2'h0, 15'h0048, 7'h00, en);
                rd(2'h0, 15'h0048, 7'h00, en);
                for (int b = 0; b < 7; b++) begin
                    d = 32'h1122_3344 + b;
                    tg(b[2:0], d, (b == w) ?
                       {d[7:0], d[15:8], d[23:16], d[31:24]} : d);
                end
            end
        end
        // Window aliases are read only
        wr(2'h1, 15'h0048, 7'h00, 32'h0000_0000);
        wr(2'h2, 15'h0048, 7'h00, 32'h0000_0000);
        rd(2'h2, 15'h0048, 7'h00, 32'h0400_0000);
        wr(2'h0, 15'h0048, 7'h00, 32'h0000_0000);
        ev(5'h10, 3'h0, 3'h0);
        rd(2'h0, 15'h0048, 7'h00, 32'h0200_0000);
        ev(5'h08, 3'h0, 3'h0);
        rd(2'h1, 15'h0048, 7'h00, 32'h0300_0000);
    endtask

    task automatic t_test;
        ev(5'h04, 3'h0, 3'h0);
        rd(2'h1, 15'h010c, 7'h00, 32'hc300_0000);
        ev(5'h01, 3'h5, 3'h2);
        rd(2'h1, 15'h010c, 7'h00, 32'hc705_4000);
        wr(2'h1, 15'h010c, 7'h00, 32'h0000_0000);
        rd(2'h1, 15'h010c, 7'h00, 32'hc705_4000);
        wr(2'h2, 15'h000c, 7'h01, 32'h0400_0000);
        rd(2'h1, 15'h010c, 7'h00, 32'hc305_4000);
        wr(2'h2, 15'h000c, 7'h01, 32'h0000_0001);
        chk({31'h0, o_start_self_test}, 32'h1);
        wr(2'h1, 15'h010c, 7'h00, 32'h0000_0002);
        chk({31'h0, o_soft_reset_req}, 32'h1);
        ev(5'h02, 3'h0, 3'h0);
        ev(5'h01, 3'h0, 3'h0);
        rd(2'h1, 15'h010c, 7'h00, 32'h9705_4000);
    endtask

    task automatic t_cpu;
        wr(2'h1, 15'h010c, 7'h00, 32'h0000_0010);
        chk({31'h0, o_local_cpu_reset}, 32'h1);
        chk({31'h0, o_flash_reset}, 32'h1);
        rd(2'h1, 15'h010c, 7'h00, 32'h9785_4000);
        wr(2'h1, 15'h010c, 7'h00, 32'h0000_0040);
        chk({31'h0, o_flash_reset}, 32'h0);
        rd(2'h1, 15'h010c, 7'h00, 32'h9785_4200);
        wr(2'h1, 15'h010c, 7'h00, 32'h0040_0000);
        chk({31'h0, o_flash_reset}, 32'h1);
        rd(2'h1, 15'h010c, 7'h00, 32'h9785_4000);
        wr(2'h1, 15'h010c, 7'h00, 32'h0080_0000);
        chk({31'h0, o_local_cpu_reset}, 32'h0);
        chk({31'h0, o_flash_reset}, 32'h0);
    endtask

    task automatic t_ext;
        logic [14:0] offs [9];
        offs = '{15'h110, 15'h114, 15'h13c, 15'h1c0, 15'h1e0,
                 15'h1e4, 15'h1e8, 15'h1ec, 15'h1f0};
        for (int i = 0; i < 9; i++) begin
            wr(2'h1, offs[i], 7'h00, 32'h0000_0000);
            chk({23'h0, o_ext_select}, 32'h1 << i);
            chk({31'h0, o_ext_write}, 32'h1);
            ast_host_model_inst.acc(1'b0, 2'h2, offs[i] - 15'h100,
                                    7'h01, 32'h0);
            chk({23'h0, o_ext_select}, 32'h1 << i);
            chk({31'h0, ast_host_model_inst.hit_q}, 32'h1);
        end
    endtask

    // Reset under a low clock enable, then a frozen firmware event
    task automatic t_hold;
        @(posedge i_clock);
        i_clock_en <= 1'b0;
        i_resetn   <= 1'b0;
        repeat (2) @(posedge i_clock);
        i_resetn   <= 1'b1;
        ev(5'h10, 3'h0, 3'h0);
        @(posedge i_clock);
        i_clock_en <= 1'b1;
        rd(2'h1, 15'h010c, 7'h00, 32'hf700_0000);
        rd(2'h0, 15'h0048, 7'h00, 32'h0000_0000);
    endtask

    task automatic finish_test;
        bad_count += ast_host_model_inst.lost;
        if (bad_count == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        i_clock = 1'b0;
        i_resetn = 1'b0;
        i_clock_en = 1'b1;
        {i_fw_self_test_done, i_fw_power_on_done, i_test_begin,
         i_soft_reset_begin, i_test_finish} = 5'h00;
        i_array_pass = 3'h0;
        i_array_fail = 3'h0;
        i_tgt_valid = 1'b0;
        i_tgt_bar = 3'h0;
        i_tgt_data = 32'h0000_0000;
        bad_count = 0;
        n_compared = 0;
        repeat (12) @(posedge i_clock);
        i_resetn <= 1'b1;
        t_reset;
        t_swap;
        t_test;
        t_cpu;
        t_ext;
        t_hold;
        finish_test;
    end
endmodule
